// ### mwd_top.sv
// Purpose: Millisecond watchdog with oscillator frequency setting, APB slave
// Assumes: SYS_CLK is the oscillator clock; power state input is on SYS_CLK
// Notes:   Zero wait states; refused writes answer with PSLVERR
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module mwd_top
(
    input  wire logic                         SYS_CLK,
    input  wire logic                         RESET,
    input  wire logic                         PSEL,
    input  wire logic                         PENABLE,
    input  wire logic                         PWRITE,
    input  wire logic [mwd_pkg::ADDR_W-1:0]   PADDR,
    input  wire logic [mwd_pkg::DATA_W-1:0]   PWDATA,
    output logic      [mwd_pkg::DATA_W-1:0]   PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR,
    input  wire logic                         RUNNING_POWER_STATE,
    output logic                              TILE_RESET_REQ,
    output logic                              WDOG_TICK,
    output logic      [mwd_pkg::FREQ_W-1:0]   OSC_FREQ_MHZ
);
    import mwd_pkg::*;

    //////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [FREQ_W-1:0]  freq_ff;
    logic [HALF_W-1:0]  tmo_ff;
    logic [HALF_W-1:0]  cnt_ff;
    logic [DATA_W-1:0]  key_ff;
    logic [DATA_W-1:0]  prdata_ff;
    logic               tile_rst_ff;
    logic [HALF_W-1:0]  nxt_cnt;
    logic               nxt_tile_rst;

    logic               setup_ph;
    logic               access_ph;
    logic               wr_xfer;
    logic [9:0]         reg_idx;
    logic               addr_aligned;
    logic               hit_freq;
    logic               hit_ctrl;
    logic               hit_key;
    logic               hit_any;
    logic [FREQ_W-1:0]  wr_freq;
    logic               freq_ok;
    logic               ctrl_ok;
    logic               wr_freq_acc;
    logic               wr_ctrl_acc;
    logic               wr_key;
    logic               wd_enabled;
    logic               tick;
    logic               restart;
    logic               expire;

    //////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup_ph     = PSEL && !PENABLE;
    assign access_ph    = PSEL && PENABLE;
    assign wr_xfer      = access_ph && PWRITE;
    assign reg_idx      = PADDR[ADDR_W-1:2];
    assign addr_aligned = (PADDR[1:0] == 2'h0);
    assign hit_freq     = addr_aligned && (reg_idx == IDX_OSC_FREQ);
    assign hit_ctrl     = addr_aligned && (reg_idx == IDX_WD_CTRL);
    assign hit_key      = addr_aligned && (reg_idx == IDX_WD_KEY);
    assign hit_any      = hit_freq || hit_ctrl || hit_key;

    // Upper bits of a frequency write must be zero too, else the value is above 100
    assign wr_freq      = PWDATA[FREQ_W-1:0];
    assign freq_ok      = (PWDATA[DATA_W-1:FREQ_W] == '0) &&
                          (wr_freq >= FREQ_MIN) && (wr_freq <= FREQ_MAX);
    assign ctrl_ok      = (PWDATA[CNT_LSB +: HALF_W] == ~PWDATA[TMO_LSB +: HALF_W]);

    assign wr_freq_acc  = wr_xfer && hit_freq && freq_ok;
    assign wr_ctrl_acc  = wr_xfer && hit_ctrl && ctrl_ok;
    assign wr_key       = wr_xfer && hit_key;

    // Answer in the access cycle; error for refused writes and unmapped addresses
    assign PREADY       = 1'b1;
    assign PSLVERR      = access_ph && (!hit_any ||
                          (PWRITE && hit_freq && !freq_ok) ||
                          (PWRITE && hit_ctrl && !ctrl_ok));

    //////////////////////////////////////////////////////////////////////////////
    // Frequency register
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            freq_ff <= FREQ_RST;
        else if (wr_freq_acc)
            freq_ff <= wr_freq;
    end

    assign OSC_FREQ_MHZ = freq_ff;

    //////////////////////////////////////////////////////////////////////////////
    // Timeout register
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            tmo_ff <= TMO_RST;
        else if (wr_ctrl_acc)
            tmo_ff <= PWDATA[TMO_LSB +: HALF_W];
    end

    //////////////////////////////////////////////////////////////////////////////
    // Disable key register; any value other than the magic key runs the watchdog
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            key_ff <= KEY_DISABLE;
        else if (wr_key)
            key_ff <= PWDATA;
    end

    assign wd_enabled = (key_ff != KEY_DISABLE);

    //////////////////////////////////////////////////////////////////////////////
    // Restart: accepted kick, enable write, or disable write; the prescaler goes back to zero
    assign restart = wr_ctrl_acc || (wr_key && (PWDATA != KEY_DISABLE)) ||
                     (wr_key && (PWDATA == KEY_DISABLE));

    mwd_tick_div
    #(
        .DIV_BITS (DIV_W)
    )
    u_tick_div
    (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .run      (wd_enabled && RUNNING_POWER_STATE),
        .restart  (restart),
        .freq_mhz (freq_ff),
        .tick     (tick)
    );

    assign WDOG_TICK = tick;

    //////////////////////////////////////////////////////////////////////////////
    // Live count. A timeout of zero expires on the first tick
    assign expire = tick && (cnt_ff <= HALF_W'(1));

    always_comb
    begin
        nxt_cnt      = cnt_ff;
        nxt_tile_rst = 1'b0;
        if (wr_key && (PWDATA == KEY_DISABLE))
            nxt_cnt = CNT_RST;
        else if (wr_ctrl_acc)
            nxt_cnt = PWDATA[TMO_LSB +: HALF_W];
        else if (wr_key)
            nxt_cnt = tmo_ff;
        else if (expire)
        begin
            // Tile reset restarts the countdown from the timeout
            nxt_cnt      = tmo_ff;
            nxt_tile_rst = 1'b1;
        end
        else if (tick)
            nxt_cnt = cnt_ff - HALF_W'(1);
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            cnt_ff <= CNT_RST;
        else
            cnt_ff <= nxt_cnt;
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            tile_rst_ff <= 1'b0;
        else
            tile_rst_ff <= nxt_tile_rst;
    end

    assign TILE_RESET_REQ = tile_rst_ff;

    //////////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup cycle; reserved bits read zero
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            prdata_ff <= '0;
        else if (setup_ph)
        begin
            if (hit_freq)
                prdata_ff <= {{(DATA_W-FREQ_W){1'b0}}, freq_ff};
            else if (hit_ctrl)
                prdata_ff <= {cnt_ff, tmo_ff};
            else if (hit_key)
                prdata_ff <= key_ff;
            else
                prdata_ff <= '0;
        end
    end

    assign PRDATA = prdata_ff;

    //////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_freq_refused;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_xfer && hit_freq && !freq_ok) |-> PSLVERR ##1 (freq_ff == $past(freq_ff));
    endproperty
    a_freq_refused: assert property (p_freq_refused)
        else $error("Out of range frequency write changed the field");

    property p_freq_taken;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_xfer && hit_freq && (PWDATA >= 32'h00000005) && (PWDATA <= 32'h00000064))
            |-> !PSLVERR ##1 (freq_ff == $past(PWDATA[6:0]));
    endproperty
    a_freq_taken: assert property (p_freq_taken)
        else $error("Valid frequency write not stored");

    property p_ctrl_nack;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_xfer && hit_ctrl && (PWDATA[31:16] != ~PWDATA[15:0]))
            |-> PSLVERR ##1 $stable(tmo_ff);
    endproperty
    a_ctrl_nack: assert property (p_ctrl_nack)
        else $error("Bad complement write not refused");

    property p_ctrl_reload;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_xfer && hit_ctrl && (PWDATA[31:16] == ~PWDATA[15:0]))
            |-> !PSLVERR ##1 (cnt_ff == $past(PWDATA[15:0])) && (tmo_ff == cnt_ff);
    endproperty
    a_ctrl_reload: assert property (p_ctrl_reload)
        else $error("Accepted kick did not reload the count");

    property p_disable_clears;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_key && (PWDATA == 32'h0d15ab1e)) |=> (cnt_ff == 16'h0000) && !wd_enabled ##1 !tick;
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("Disable key did not stop the watchdog");

    property p_hold_asleep;
        @(posedge SYS_CLK) disable iff (RESET)
        (!RUNNING_POWER_STATE && !wr_ctrl_acc && !wr_key) |=> $stable(cnt_ff) && !TILE_RESET_REQ;
    endproperty
    a_hold_asleep: assert property (p_hold_asleep)
        else $error("Count moved outside the running power state");

    property p_expire_reset;
        @(posedge SYS_CLK) disable iff (RESET)
        (tick && (cnt_ff == 16'h0001) && !wr_ctrl_acc && !wr_key)
            |=> TILE_RESET_REQ && (cnt_ff == tmo_ff) ##1 !TILE_RESET_REQ;
    endproperty
    a_expire_reset: assert property (p_expire_reset)
        else $error("Expiry did not pulse the tile reset");

    property p_tick_decrement;
        @(posedge SYS_CLK) disable iff (RESET)
        (tick && (cnt_ff > 16'h0001) && !wr_ctrl_acc && !wr_key)
            |=> (cnt_ff == $past(cnt_ff) - 16'h0001);
    endproperty
    a_tick_decrement: assert property (p_tick_decrement)
        else $error("Count did not step down on a tick");

    property p_enable_zero;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_key && (PWDATA == 32'h00000000)) |=> wd_enabled && (cnt_ff == tmo_ff);
    endproperty
    a_enable_zero: assert property (p_enable_zero)
        else $error("Zero key did not enable the watchdog");

    property p_no_early_tick;
        @(posedge SYS_CLK) disable iff (RESET)
        (tick && (freq_ff == 7'h05)) |=> !tick [*8];
    endproperty
    a_no_early_tick: assert property (p_no_early_tick)
        else $error("Ticks closer than one millisecond");

    property p_read_ctrl;
        @(posedge SYS_CLK) disable iff (RESET)
        (setup_ph && hit_ctrl) |=> (PRDATA == {$past(cnt_ff), $past(tmo_ff)});
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("Control read did not show count and timeout");

    //////////////////////////////////////////////////////////////////////////////
    // Checker helpers: running cycles since the last tick or restart, and no frequency write in that span
    logic [DIV_W-1:0]   chk_run_cyc_ff;
    logic               chk_clean_ff;

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            chk_run_cyc_ff <= '0;
        else if (restart || tick)
            chk_run_cyc_ff <= '0;
        else if (wd_enabled && RUNNING_POWER_STATE)
            chk_run_cyc_ff <= chk_run_cyc_ff + DIV_W'(1);
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
            chk_clean_ff <= 1'b1;
        else if (restart || tick)
            chk_clean_ff <= 1'b1;
        else if (wr_freq_acc)
            chk_clean_ff <= 1'b0;
    end

    property p_tick_period;
        @(posedge SYS_CLK) disable iff (RESET)
        (tick && chk_clean_ff) |-> ((chk_run_cyc_ff + 17'h00001) == ({10'h000, freq_ff} * 17'h003e8));
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("Tick spacing differs from the programmed frequency");

    property p_tick_only_running;
        @(posedge SYS_CLK) disable iff (RESET)
        !RUNNING_POWER_STATE |-> !WDOG_TICK;
    endproperty
    a_tick_only_running: assert property (p_tick_only_running)
        else $error("Tick outside the running power state");

    property p_reset_one_cycle;
        @(posedge SYS_CLK) disable iff (RESET)
        TILE_RESET_REQ |=> !TILE_RESET_REQ;
    endproperty
    a_reset_one_cycle: assert property (p_reset_one_cycle)
        else $error("Tile reset request longer than one cycle");

    property p_reset_cause;
        @(posedge SYS_CLK) disable iff (RESET)
        TILE_RESET_REQ |-> $past(tick) && ($past(cnt_ff) <= 16'h0001);
    endproperty
    a_reset_cause: assert property (p_reset_cause)
        else $error("Tile reset request without an expiry");

    property p_freq_in_range;
        @(posedge SYS_CLK) disable iff (RESET)
        (OSC_FREQ_MHZ >= 7'h05) && (OSC_FREQ_MHZ <= 7'h64);
    endproperty
    a_freq_in_range: assert property (p_freq_in_range)
        else $error("Frequency field left the valid range");

    property p_ctrl_nack_count;
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_xfer && hit_ctrl && (PWDATA[31:16] != ~PWDATA[15:0]) && !tick) |=> $stable(cnt_ff);
    endproperty
    a_ctrl_nack_count: assert property (p_ctrl_nack_count)
        else $error("Refused control write moved the count");

    property p_count_bounded;
        @(posedge SYS_CLK) disable iff (RESET)
        cnt_ff <= tmo_ff;
    endproperty
    a_count_bounded: assert property (p_count_bounded)
        else $error("Live count above the programmed timeout");

    property p_freq_read;
        @(posedge SYS_CLK) disable iff (RESET)
        (setup_ph && hit_freq) |=> (PRDATA == {25'h0, $past(OSC_FREQ_MHZ)});
    endproperty
    a_freq_read: assert property (p_freq_read)
        else $error("Frequency read did not show the field");

endmodule

// ### mwd_pkg.sv
// Purpose: Constants for the millisecond watchdog and oscillator frequency setting
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Printed offsets are register indexes; byte address is four times the index
package mwd_pkg;

    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned DATA_W       = 32;

    // Register indexes; the bus address is four times these
    localparam logic [9:0]  IDX_OSC_FREQ = 10'h051;
    localparam logic [9:0]  IDX_WD_CTRL  = 10'h0d6;
    localparam logic [9:0]  IDX_WD_KEY   = 10'h0d7;

    // Field layout of the frequency register
    localparam int unsigned FREQ_W       = 7;
    localparam logic [6:0]  FREQ_RST     = 7'h19;
    localparam logic [6:0]  FREQ_MIN     = 7'h05;
    localparam logic [6:0]  FREQ_MAX     = 7'h64;

    // Field layout of the watchdog control register
    localparam int unsigned HALF_W       = 16;
    localparam int unsigned TMO_LSB      = 0;
    localparam int unsigned CNT_LSB      = 16;
    localparam logic [15:0] TMO_RST      = 16'h03e8;
    localparam logic [15:0] CNT_RST      = 16'h0000;

    // Disable key
    localparam logic [31:0] KEY_DISABLE  = 32'h0d15ab1e;
    localparam logic [31:0] KEY_ENABLE   = 32'h00000000;

    // Tick timing: one tick is 1 ms, i.e. 1000 oscillator microseconds
    localparam int unsigned TICK_PERIOD_US = 1000;
    localparam int unsigned DIV_W          = 17;
    localparam logic [9:0]  KHZ_PER_MHZ    = 10'(TICK_PERIOD_US);

endpackage

// ### mwd_tick_div.sv
// Purpose: Divides the oscillator clock down to a 1 ms tick
// Assumes: Frequency input is already range checked
// Notes:   Restart clears the prescaler so a reload gives a full first tick
`timescale 1ns/1ps
module mwd_tick_div
#(
    parameter int unsigned DIV_BITS = mwd_pkg::DIV_W
)
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       run,
    input  wire logic                       restart,
    input  wire logic [mwd_pkg::FREQ_W-1:0] freq_mhz,
    output logic                            tick
);
    import mwd_pkg::*;

    logic [DIV_BITS-1:0] div_cnt_ff;
    logic [DIV_BITS-1:0] div_last;

    // Refuse a prescaler too narrow for the 100 MHz divisor
    if (DIV_BITS < DIV_W)
    begin : g_div_bits_check
        $error("mwd_tick_div: DIV_BITS too small for 100 MHz");
    end

    // Divisor is freq * 1000 cycles per tick; widen first so the product is not cut to 10 bits
    assign div_last = DIV_BITS'(freq_mhz) * DIV_BITS'(KHZ_PER_MHZ) - DIV_BITS'(1);

    //////////////////////////////////////////////////////////////////////////////
    // Prescaler holds outside the running state so no partial tick is lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_cnt_ff <= '0;
        else if (restart)
            div_cnt_ff <= '0;
        else if (run)
        begin
            if (div_cnt_ff >= div_last)
                div_cnt_ff <= '0;
            else
                div_cnt_ff <= div_cnt_ff + DIV_BITS'(1);
        end
    end

    assign tick = run && !restart && (div_cnt_ff >= div_last);

endmodule

// ### millisecond_watchdog_with_clock_setting_test.sv
// Purpose: Self-checking bench for the millisecond watchdog and frequency setting
// Assumes: Zero wait state APB slave; frequency 5 MHz gives 5000 cycles a tick
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module millisecond_watchdog_with_clock_setting_test;
    import mwd_pkg::*;

    localparam logic [11:0] A_FREQ = {IDX_OSC_FREQ, 2'b00};
    localparam logic [11:0] A_CTRL = {IDX_WD_CTRL, 2'b00};
    localparam logic [11:0] A_KEY  = {IDX_WD_KEY, 2'b00};
    localparam logic [11:0] A_NONE = 12'h100;
    localparam int          TICK_N = TICK_PERIOD_US * 5;

    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic        power   = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tile_rst;
    logic        wd_tick;
    logic [6:0]  osc_mhz;
    int          err_count = 0;
    int          checks    = 0;
    int          rst_pulses = 0;

    mwd_top dut_u
    (
        .SYS_CLK             (sys_clk),
        .RESET               (reset),
        .PSEL                (psel),
        .PENABLE             (penable),
        .PWRITE              (pwrite),
        .PADDR               (paddr),
        .PWDATA              (pwdata),
        .PRDATA              (prdata),
        .PREADY              (pready),
        .PSLVERR             (pslverr),
        .RUNNING_POWER_STATE (power),
        .TILE_RESET_REQ      (tile_rst),
        .WDOG_TICK           (wd_tick),
        .OSC_FREQ_MHZ        (osc_mhz)
    );

    always #10 sys_clk = ~sys_clk;

    // Counts tile reset pulses so a scenario can tell that none came
    always @(posedge sys_clk)
        if (tile_rst === 1'b1)
            rst_pulses <= rst_pulses + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Request held until the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        check("pready", {31'h0, pready}, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for a tick pulse; seen tells whether one came
    task automatic wait_tick(input int lim, output int n, output logic seen);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wd_tick !== 1'b1 && n < lim);
        seen = wd_tick;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [31:0] d;
        logic        e;
        check("osc out", {25'h0, osc_mhz}, 32'h19);
        apb(1'b0, A_FREQ, 32'h0, d, e);
        check("freq rst", d, 32'h00000019);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("ctrl rst", d, 32'h000003e8);
        apb(1'b0, A_KEY, 32'h0, d, e);
        check("key rst", d, 32'h0d15ab1e);
        apb(1'b0, A_NONE, 32'h0, d, e);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", d, 32'h0);
    endtask

    task automatic t_freq_range();
        logic [31:0] d;
        logic        e;
        logic [31:0] v [4] = '{32'h4, 32'h65, 32'h64, 32'h5};
        logic [31:0] x [4] = '{32'h19, 32'h19, 32'h64, 32'h5};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, A_FREQ, v[i], d, e);
            check("freq nack", {31'h0, e}, {31'h0, i < 2});
            apb(1'b0, A_FREQ, 32'h0, d, e);
            check("freq value", d, x[i]);
            check("osc out", {25'h0, osc_mhz}, x[i]);
        end
    endtask

    task automatic t_ctrl_write();
        logic [31:0] d;
        logic        e;
        apb(1'b1, A_CTRL, 32'hfffd0003, d, e);
        check("ctrl bad nack", {31'h0, e}, 32'h1);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("ctrl unchanged", {16'h0, d[15:0]}, 32'h3e8);
        apb(1'b1, A_CTRL, 32'hfffc0003, d, e);
        check("ctrl ok ack", {31'h0, e}, 32'h0);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("ctrl timeout", {16'h0, d[15:0]}, 32'h3);
    endtask

    // Countdown from 3: reload, exact tick spacing, hold when asleep, expiry
    task automatic t_countdown();
        logic [31:0] d;
        logic        e;
        logic        s;
        int          n;
        apb(1'b1, A_KEY, KEY_ENABLE, d, e);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("count loaded", d, 32'h00030003);
        wait_tick(TICK_N + 100, n, s);
        check("first tick", {31'h0, s}, 32'h1);
        wait_tick(TICK_N + 100, n, s);
        check("tick spacing", n, TICK_N);
        check("no early expiry", {31'h0, tile_rst}, 32'h0);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("count down", {16'h0, d[31:16]}, 32'h1);
        power <= 1'b0;
        wait_tick(TICK_N + 1000, n, s);
        check("asleep no tick", {31'h0, s}, 32'h0);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("asleep hold", {16'h0, d[31:16]}, 32'h1);
        power <= 1'b1;
        wait_tick(TICK_N + 100, n, s);
        @(posedge sys_clk);
        check("expiry reset", {31'h0, tile_rst}, 32'h1);
        @(posedge sys_clk);
        check("reset pulse", {31'h0, tile_rst}, 32'h0);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("reload", d, 32'h00030003);
    endtask

    // Kicks inside the timeout keep the tile out of reset
    task automatic t_kick();
        logic [31:0] d;
        logic        e;
        logic        s;
        int          n;
        int          p;
        p = rst_pulses;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, A_CTRL, 32'hfffc0003, d, e);
            check("kick ack", {31'h0, e}, 32'h0);
            wait_tick(TICK_N + 100, n, s);
            check("kick restarts tick", n, TICK_N);
            apb(1'b0, A_CTRL, 32'h0, d, e);
            check("kick count", d, 32'h00020003);
        end
        check("kick no reset", rst_pulses - p, 0);
    endtask

    // Reset in mid-run brings every register back to its reset value
    task automatic t_reset_mid();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_values();
    endtask

    task automatic t_disable();
        logic [31:0] d;
        logic        e;
        logic        s;
        int          n;
        apb(1'b1, A_KEY, KEY_DISABLE, d, e);
        apb(1'b0, A_CTRL, 32'h0, d, e);
        check("stopped count", {16'h0, d[31:16]}, 32'h0);
        apb(1'b0, A_KEY, 32'h0, d, e);
        check("key magic", d, 32'h0d15ab1e);
        wait_tick(TICK_N + 1000, n, s);
        check("disabled no tick", {31'h0, s}, 32'h0);
        check("disabled no reset", {31'h0, tile_rst}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Whole run needs about 42000 cycles; the limit leaves ample room
    initial
    begin
        #1200000;
        err_count++;
        final_report();
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_values();
        t_freq_range();
        t_ctrl_write();
        t_countdown();
        t_kick();
        t_disable();
        t_reset_mid();
        final_report();
    end
endmodule
